// ---- core/xlw_consts.svh ----
// Constants for the exclusive-OR datapath block.
`ifndef XLW_CONSTS_SVH
`define XLW_CONSTS_SVH
`define XLW_OP_LIT_HI       8'h0a
`define XLW_OP_FILE_HI      6'h06
`define XLW_IDX_LIMIT       8'h5f
`define XLW_ACCESS_SPLIT    8'h60
`define XLW_ACCESS_HI_BANK  4'hf
`define XLW_ZERO_BYTE       8'h00
`define XLW_W_RESET         8'h00
`define XLW_DEST_BIT        9
`define XLW_ACC_BIT         8
`define XLW_NEG_BIT         7
`endif

// ---- core/xlw_pkg.sv ----
// Types shared by the exclusive-OR datapath block.
package xlw_pkg;
    typedef enum logic [1:0] {
        XLW_Q1_DECODE,
        XLW_Q2_READ,
        XLW_Q3_PROCESS,
        XLW_Q4_WRITE
    } xlw_phase_type;

    typedef enum logic [1:0] {
        XLW_ADDR_ACCESS,
        XLW_ADDR_BANKED,
        XLW_ADDR_INDEXED
    } xlw_addr_mode_type;
endpackage : xlw_pkg

// ---- core/xlw_addr_gen.sv ----
// File-operand address generation for the exclusive-OR datapath.
`timescale 1ns/1ps
`default_nettype none
`include "xlw_consts.svh"
module xlw_addr_gen
(
    input  wire logic                      access_sel,
    input  wire logic                      ext_enable,
    input  wire logic [7:0]                file_field,
    input  wire logic [3:0]                bank_select_register,
    input  wire logic [11:0]               index_base,
    output logic [11:0]                    file_addr,
    output xlw_pkg::xlw_addr_mode_type     addr_mode
);
    import xlw_pkg::*;

    always_comb
    begin
        if (!access_sel && ext_enable && file_field <= `XLW_IDX_LIMIT)
        begin
            // The field is an offset from the index pointer.
            addr_mode = XLW_ADDR_INDEXED; // RULE5 RULE7
            file_addr = index_base + {4'h0, file_field};
        end
        else if (access_sel)
        begin
            addr_mode = XLW_ADDR_BANKED; // RULE4
            file_addr = {bank_select_register, file_field};
        end
        else
        begin
            // Low half maps to bank 0, high half to the special registers.
            addr_mode = XLW_ADDR_ACCESS; // RULE4
            if (file_field < `XLW_ACCESS_SPLIT)
                file_addr = {4'h0, file_field};
            else
                file_addr = {`XLW_ACCESS_HI_BANK, file_field};
        end
    end
endmodule : xlw_addr_gen
`default_nettype wire

// ---- core/xlw_xor_unit.sv ----
// Exclusive-OR datapath for the literal and file-register instructions.
//
// Functional notes
// RULE1 - A literal opcode with high byte 0000 1010 XORs W with the low byte into W.
// RULE2 - A 0001 10da opcode XORs W with the addressed file register.
// RULE3 - Destination bit 1 writes the file register, bit 0 writes W.
// RULE4 - Access bit 0 uses the access bank, access bit 1 uses the bank select register.
// RULE5 - Access bit 0 with extended set on and field at most 5Fh uses indexed offset addressing.
// RULE6 - Both update only negative and zero flags, one word, one instruction cycle.
// RULE7 - Indexed offset addressing is off unless the extended set enable bit is set.
`timescale 1ns/1ps
`default_nettype none
`include "xlw_consts.svh"
module xlw_xor_unit
(
    input  wire logic        core_clk,
    input  wire logic        rst_b,
    input  wire logic        instr_valid,
    input  wire logic [15:0] opcode,
    input  wire logic [3:0]  bank_select_register,
    input  wire logic        extended_set_enable_bit,
    input  wire logic [11:0] index_base,
    input  wire logic [7:0]  file_rdata,
    output logic             instr_accept,
    output logic [11:0]      file_addr,
    output logic             file_rd,
    output logic             file_we,
    output logic [7:0]       file_wdata,
    output logic [7:0]       working_reg,
    output logic             flag_negative,
    output logic             flag_zero,
    output logic             instr_done,
    output xlw_pkg::xlw_phase_type phase
);
    import xlw_pkg::*;

    // ****************************************
    // Decode helpers
    // ****************************************
    function automatic logic is_lit(input logic [15:0] op);
        is_lit = (op[15:8] == `XLW_OP_LIT_HI);
    endfunction : is_lit

    function automatic logic is_file(input logic [15:0] op);
        is_file = (op[15:10] == `XLW_OP_FILE_HI);
    endfunction : is_file

    // A literal word never writes the file, whatever its low bits say.
    function automatic logic writes_file(input logic [15:0] op);
        writes_file = is_file(op) && op[`XLW_DEST_BIT];
    endfunction : writes_file

    // Negative flag in bit 1, zero flag in bit 0.
    function automatic logic [1:0] nz_of(input logic [7:0] value);
        nz_of = {value[`XLW_NEG_BIT], (value == `XLW_ZERO_BYTE)};
    endfunction : nz_of

    // ****************************************
    // Elaboration checks
    // ****************************************
    // The decode relies on these positions lying inside the word, and on
    // indexed offsets never reaching the high half of the access bank.
    if (`XLW_DEST_BIT >= 16 || `XLW_ACC_BIT >= 16)
    begin : g_bad_bits
        $error("opcode bit positions out of range");
    end
    if (`XLW_NEG_BIT >= 8)
    begin : g_bad_sign
        $error("sign bit outside the data byte");
    end
    if (`XLW_IDX_LIMIT >= `XLW_ACCESS_SPLIT)
    begin : g_bad_split
        $error("indexed limit overlaps the high access half");
    end

    // ****************************************
    // Limitations
    // ****************************************
    // W is read from this block's own register in the process phase, so a
    // file write aimed at W's data address is not seen by W here; the core
    // must route such a write back itself.
    // The other status bits live outside this block, which only ever
    // drives the negative and zero flags.

    // ****************************************
    // State
    // ****************************************
    xlw_phase_type     next_phase;
    logic [15:0]       instr;
    logic [15:0]       next_instr;
    logic [7:0]        operand;
    logic [7:0]        next_operand;
    logic [7:0]        result;
    logic [7:0]        next_result;
    logic [7:0]        next_working_reg;
    logic              next_flag_negative;
    logic              next_flag_zero;
    logic [11:0]       addr_q;
    logic [11:0]       next_addr_q;
    logic              next_file_we;
    logic [7:0]        next_file_wdata;
    logic              next_instr_done;
    logic [11:0]       gen_addr;
    logic              idle_ok;

    xlw_addr_gen u_addr
    (
        .access_sel           (opcode[`XLW_ACC_BIT]),
        .ext_enable           (extended_set_enable_bit),
        .file_field           (opcode[7:0]),
        .bank_select_register (bank_select_register),
        .index_base           (index_base),
        .file_addr            (gen_addr),
        .addr_mode            ()
    );

    // Only supported opcodes are taken, and only at the decode phase.
    assign idle_ok      = (phase == XLW_Q1_DECODE);
    assign instr_accept = idle_ok && instr_valid
                          && (is_lit(opcode) || is_file(opcode));
    assign file_addr    = addr_q;
    assign file_rd      = (phase == XLW_Q2_READ) && is_file(instr);

    // ****************************************
    // Next-state logic
    // ****************************************
    always_comb
    begin
        next_phase         = phase;
        next_instr         = instr;
        next_operand       = operand;
        next_result        = result;
        next_working_reg   = working_reg;
        next_flag_negative = flag_negative;
        next_flag_zero     = flag_zero;
        next_addr_q        = addr_q;
        next_file_we       = 1'b0;
        next_file_wdata    = file_wdata;
        next_instr_done    = 1'b0;
        unique case (phase)
            XLW_Q1_DECODE:
            begin
                if (instr_accept)
                begin
                    next_instr  = opcode;
                    next_addr_q = gen_addr; // RULE4 RULE5
                    next_phase  = XLW_Q2_READ;
                end
            end
            XLW_Q2_READ:
            begin
                if (is_lit(instr))
                    next_operand = instr[7:0]; // RULE1
                else
                    next_operand = file_rdata; // RULE2
                next_phase = XLW_Q3_PROCESS;
            end
            XLW_Q3_PROCESS:
            begin
                next_result = working_reg ^ operand; // RULE1 RULE2
                next_phase  = XLW_Q4_WRITE;
            end
            XLW_Q4_WRITE:
            begin
                // Only N and Z change; other status bits are not held here.
                next_flag_negative = nz_of(result)[1]; // RULE6
                next_flag_zero     = nz_of(result)[0]; // RULE6
                if (writes_file(instr))
                begin
                    next_file_we    = 1'b1; // RULE3
                    next_file_wdata = result;
                end
                else
                    next_working_reg = result; // RULE1 RULE3
                next_instr_done = 1'b1; // RULE6
                next_phase      = XLW_Q1_DECODE;
            end
        endcase
    end

    // ****************************************
    // Registers
    // ****************************************
    always_ff @(posedge core_clk)
    begin
        if (!rst_b)
        begin
            phase         <= XLW_Q1_DECODE;
            instr         <= 16'h0000;
            operand       <= `XLW_ZERO_BYTE;
            result        <= `XLW_ZERO_BYTE;
            working_reg   <= `XLW_W_RESET;
            flag_negative <= 1'b0;
            flag_zero     <= 1'b0;
            addr_q        <= 12'h000;
            file_we       <= 1'b0;
            file_wdata    <= `XLW_ZERO_BYTE;
            instr_done    <= 1'b0;
        end
        else
        begin
            phase         <= next_phase;
            instr         <= next_instr;
            operand       <= next_operand;
            result        <= next_result;
            working_reg   <= next_working_reg;
            flag_negative <= next_flag_negative;
            flag_zero     <= next_flag_zero;
            addr_q        <= next_addr_q;
            file_we       <= next_file_we;
            file_wdata    <= next_file_wdata;
            instr_done    <= next_instr_done;
        end
    end
endmodule : xlw_xor_unit
`default_nettype wire

// ---- bench/xlw_xor_unit_properties.sv ----
// Concurrent checks on the ports of the exclusive-OR datapath.
`timescale 1ns/1ps
`default_nettype none
module xlw_xor_unit_properties
(
    input wire logic        core_clk,
    input wire logic        rst_b,
    input wire logic        instr_accept,
    input wire logic [15:0] opcode,
    input wire logic [3:0]  bank_select_register,
    input wire logic        extended_set_enable_bit,
    input wire logic [11:0] index_base,
    input wire logic [11:0] file_addr,
    input wire logic        file_rd,
    input wire logic        file_we,
    input wire logic [7:0]  working_reg,
    input wire logic        flag_negative,
    input wire logic        flag_zero,
    input wire logic        instr_done
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (!rst_b);
    wire file_op = instr_accept && opcode[15:10] == 6'h06;
    done_timing_a: assert property (
        instr_accept |=> !instr_done [*3] ##1 instr_done)
        else $error("done pulse not four cycles after accept");
    literal_result_a: assert property (
        instr_accept && opcode[15:8] == 8'h0a |-> ##4
        working_reg == ($past(working_reg, 4) ^ $past(opcode[7:0], 4)))
        else $error("literal result wrong");
    file_read_a: assert property (file_op |=> file_rd)
        else $error("file read missing");
    file_dest_a: assert property (
        file_op |-> ##4 file_we == $past(opcode[9], 4))
        else $error("file write does not follow destination bit");
    banked_addr_a: assert property (
        file_op && opcode[8] |=> file_addr ==
        {$past(bank_select_register), $past(opcode[7:0])})
        else $error("banked address wrong");
    indexed_addr_a: assert property (
        file_op && !opcode[8] && extended_set_enable_bit &&
        opcode[7:0] <= 8'h5f |=>
        file_addr == $past(index_base) + {4'h0, $past(opcode[7:0])})
        else $error("indexed address wrong");
    access_addr_a: assert property (
        file_op && !opcode[8] && !extended_set_enable_bit |=> file_addr ==
        {$past(opcode[7:0]) < 8'h60 ? 4'h0 : 4'hf, $past(opcode[7:0])})
        else $error("access bank address wrong");
    flag_update_a: assert property (
        instr_done && !file_we |-> flag_negative == working_reg[7] &&
        flag_zero == (working_reg == 8'h00))
        else $error("flags do not match result");
endmodule : xlw_xor_unit_properties
bind xlw_xor_unit xlw_xor_unit_properties u_props
(
    .core_clk(core_clk), .rst_b(rst_b), .instr_accept(instr_accept),
    .opcode(opcode), .bank_select_register(bank_select_register),
    .extended_set_enable_bit(extended_set_enable_bit),
    .index_base(index_base), .file_addr(file_addr), .file_rd(file_rd),
    .file_we(file_we), .working_reg(working_reg),
    .flag_negative(flag_negative), .flag_zero(flag_zero),
    .instr_done(instr_done)
);
`default_nettype wire

// ---- bench/xlw_xor_unit_test.sv ----
// Self-checking bench for the exclusive-OR datapath.
`timescale 1ns/1ps
`default_nettype none
module xlw_xor_unit_test;
    import xlw_pkg::*;
    logic          core_clk = 0, rst_b = 0, valid = 0, ext = 0;
    logic [15:0]   opcode = 16'h0000;
    logic [3:0]    bank = 4'h0;
    logic [7:0]    rdata = 8'h00;
    logic          accept, rd, we, done, neg, zero, seen_rd;
    logic [11:0]   addr, seen_addr, lat;
    logic [7:0]    wdata, wreg;
    xlw_phase_type phase;
    int            errors = 0, samples_checked = 0, cycles = 0;
    always #50 core_clk = ~core_clk;
    xlw_xor_unit u_dut
    (
        .core_clk(core_clk), .rst_b(rst_b), .instr_valid(valid),
        .opcode(opcode), .bank_select_register(bank),
        .extended_set_enable_bit(ext), .index_base(12'h123),
        .file_rdata(rdata), .instr_accept(accept), .file_addr(addr),
        .file_rd(rd), .file_we(we), .file_wdata(wdata), .working_reg(wreg),
        .flag_negative(neg), .flag_zero(zero), .instr_done(done),
        .phase(phase)
    );
    task automatic check(input logic [11:0] got, input logic [11:0] exp);
        samples_checked++;
        if (got !== exp)
        begin
            errors++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check
    // Drives one word; returns at the falling edge where done shows, or nine falling edges after driving it if done never shows.
    task automatic run(input logic [15:0] op);
        opcode = op;
        valid = 1;
        lat = 12'h000;
        @(negedge core_clk);
        valid = 0;
        seen_addr = addr;
        seen_rd = rd;
        while (done !== 1'b1 && lat < 12'h008)
        begin
            @(negedge core_clk);
            lat++;
        end
    endtask : run
    task automatic summarize;
        $display("errors %0d samples_checked %0d", errors, samples_checked);
        if (errors == 0 && samples_checked > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : summarize
    always @(posedge core_clk)
    begin
        cycles++;
        if (cycles == 400)
        begin
            errors++;
            summarize;
        end
    end
    initial
    begin
        repeat (3) @(negedge core_clk);
        rst_b = 1;
        run(16'h0ab5);
        run(16'h0aaf);
        check({4'h0, wreg}, 12'h01a);
        check({10'h000, neg, zero}, 12'h000);
        check(lat, 12'h003);
        check({11'h000, seen_rd}, 12'h000);
        check({10'h000, phase}, {10'h000, XLW_Q1_DECODE});
        run(16'h0a1a);
        check({10'h000, neg, zero}, 12'h001);
        run(16'h0aaf);
        check({10'h000, neg, zero}, 12'h002);
        run(16'h0a1a);
        rdata = 8'haf;
        run(16'h1a20);
        check(seen_addr, 12'h020);
        check({11'h000, seen_rd}, 12'h001);
        check({3'h0, we, wdata}, 12'h11a);
        check({4'h0, wreg}, 12'h0b5);
        bank = 4'h3;
        run(16'h1980);
        check(seen_addr, 12'h380);
        check({3'h0, we, wreg}, 12'h01a);
        run(16'h1870);
        check(seen_addr, 12'hf70);
        ext = 1;
        run(16'h185f);
        check(seen_addr, 12'h182);
        run(16'h1860);
        check(seen_addr, 12'hf60);
        ext = 0;
        run(16'h1810);
        check(seen_addr, 12'h010);
        run(16'h0b00);
        check(lat, 12'h008);
        check({4'h0, wreg}, 12'h01a);
        summarize;
    end
endmodule : xlw_xor_unit_test
`default_nettype wire
